// ===== core/rfl_pkg.sv
// Shared constants and types for the frame length control block
package rfl_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_RX_LEN_HIGH     = 8'h3A;
  localparam logic [7:0] IDX_RX_LEN_LOW      = 8'h3B;
  localparam logic [7:0] IDX_TX_SETTINGS     = 8'h3C;
  localparam logic [7:0] IDX_TX_LEN_HIGH_MID = 8'h3D;
  localparam logic [7:0] IDX_TX_LEN_LOW_PART = 8'h3E;
  localparam logic [7:0] IDX_FIFO_PORT       = 8'h3F;
  // Local control and status registers, byte addresses
  localparam logic [9:0] ADDR_COMMAND        = 10'h000;
  localparam logic [9:0] ADDR_IRQ_STATUS     = 10'h004;
  localparam logic [9:0] ADDR_IRQ_MASK       = 10'h008;
  localparam logic [9:0] ADDR_FIFO_STATUS    = 10'h00C;

  localparam logic [7:0] RST_BYTE            = 8'h00;
  localparam logic [5:0] RST_IRQ             = 6'h00;

  // Fields of rx_length_control_high
  localparam int BIT_RX_SKIP_CRC   = 7;
  localparam int BIT_RAW_FIFO      = 6;
  localparam int BIT_REPEAT_IRQ    = 5;
  localparam int BIT_AUTO_ERRCODE  = 4;
  // Fields of transmit_settings
  localparam int BIT_TX_SHORT_CRC  = 3;
  localparam int BIT_FORCE_CAL     = 2;

  // Interrupt status bit positions
  localparam int IRQ_TX_DONE       = 0;
  localparam int IRQ_RX_DONE       = 1;
  localparam int IRQ_HEADER        = 2;
  localparam int IRQ_SECOND_BYTE   = 3;
  localparam int IRQ_LENGTH_ERROR  = 4;
  localparam int IRQ_FIFO_OVERFLOW = 5;
  localparam int IRQ_BITS          = 6;

  // Direct command codes
  localparam logic [7:0] CMD_TX_WITH_CRC    = 8'h90;
  localparam logic [7:0] CMD_TX_ALT         = 8'h91;
  localparam logic [7:0] CMD_QUERY          = 8'h98;
  localparam logic [7:0] CMD_SHORT_LAST     = 8'h9C;
  localparam logic [7:0] CMD_SHORT_LONG     = 8'h9F;

  // Receive lengths in bits
  localparam logic [11:0] LEN_SHORT_REPLY   = 12'h010;
  localparam logic [11:0] LEN_LONG_REPLY    = 12'h020;
  localparam logic [11:0] LEN_ERROR_CODE    = 12'h029;
  localparam logic [12:0] RX_CRC_BITS       = 13'h0010;

  localparam int FIFO_DEPTH = 24;
  localparam int BYTE_W     = 8;

  typedef struct packed {
    logic       query;
    logic       calibration;
    logic       short_crc;
    logic [1:0] session;
  } rfl_tx_hdr_t;
endpackage : rfl_pkg

// ===== core/rfl_fifo.sv
// Cyclic byte FIFO with registered read data
`timescale 1ns/1ns
module rfl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 24
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       push,
  input  wire logic [WIDTH-1:0]           wr_data,
  input  wire logic                       pop,
  output logic      [WIDTH-1:0]           rd_data,
  output logic      [$clog2(DEPTH+1)-1:0] count,
  output logic                            empty,
  output logic                            full,
  output logic                            overflow
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("rfl_fifo: unsupported DEPTH or WIDTH");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic             do_push;
  logic             do_pop;

  assign empty    = (count == '0);
  assign full     = (count == FULL_COUNT);
  // Pop and push together on a full FIFO still drops the push
  assign do_push  = push && !full;
  assign do_pop   = pop && !empty;
  assign overflow = push && full;

  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count      <= '0;
      rd_data    <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
        rd_data    <= mem[rd_ptr_reg];
      end else if (pop) begin
        rd_data    <= '0;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : rfl_fifo

// ===== core/rfl_frame_ctrl.sv
// Frame length control with AHB-Lite registers and two byte FIFOs
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - Skip-CRC bit makes reception expect and check no CRC field.
// - Raw mode stores every byte incl. CRC, second-byte irq replaces header.
// - Repeat bit adds irqs after bytes four and six; host may clear it.
// - Auto error-code on and header bit one: expected length becomes 41.
// - Short commands preset length: 16 bits for 98h-9Ch, 32 for 9Fh.
// - Short CRC bit zero selects CRC-16, one selects CRC-5.
// - Calibration sent with Query, also with 90h/91h when forced.
// - Query carries the two session bits from transmit settings.
// - Transmit length is a 12-bit byte count split over two registers.
// - Partial byte field gives bits sent from the final byte.
// - One port address reaches a 24-byte FIFO per direction.
// - Reception ending short of expected length flags a length error.
module rfl_frame_ctrl #(
  parameter int FIFO_DEPTH = rfl_pkg::FIFO_DEPTH
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic      [31:0]         hrdata,
  output logic                     hresp,
  output logic                     irq,
  output logic                     tx_frame_start,
  output rfl_pkg::rfl_tx_hdr_t     tx_hdr,
  output logic                     tx_bit,
  output logic                     tx_bit_valid,
  input  wire logic                tx_bit_ready,
  output logic                     tx_busy,
  output logic                     rx_crc_check_en,
  input  wire logic                rx_start,
  input  wire logic                rx_bit_valid,
  input  wire logic                rx_bit,
  input  wire logic                rx_end
);
  localparam int CW = $clog2(FIFO_DEPTH+1);

  initial begin
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 31) begin
      $error("rfl_frame_ctrl: FIFO_DEPTH out of range");
    end
  end

  // Maps a byte address to a register index; low bits must be zero
  function automatic logic is_idx(input logic [31:0] a,
                                  input logic [7:0] idx);
    return (a[31:10] == '0) && (a[9:2] == idx) && (a[1:0] == 2'b00);
  endfunction : is_idx

  function automatic logic is_own(input logic [31:0] a,
                                  input logic [9:0] off);
    return (a[31:10] == '0) && (a[9:0] == off);
  endfunction : is_own

  logic [7:0]  rx_len_high_reg;
  logic [7:0]  rx_len_low_reg;
  logic [7:0]  tx_settings_reg;
  logic [7:0]  tx_len_high_reg;
  logic [7:0]  tx_len_low_reg;
  logic [rfl_pkg::IRQ_BITS-1:0] irq_status_reg;
  logic [rfl_pkg::IRQ_BITS-1:0] irq_mask_reg;
  logic [rfl_pkg::IRQ_BITS-1:0] irq_set;

  // Bus data phase state
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic        rd_wait_reg;
  logic [31:0] addr_reg;
  logic        accept;
  logic        wr_now;
  logic [7:0]  wbyte;
  logic [7:0]  cmd_code;
  logic        cmd_write;

  assign accept    = hsel && htrans[1] && hready;
  assign hreadyout = !rd_pend_reg;
  assign hresp     = 1'b0;
  assign wr_now    = wr_pend_reg;
  assign wbyte     = hwdata[7:0];
  assign cmd_write = wr_now && is_own(addr_reg, rfl_pkg::ADDR_COMMAND);
  assign cmd_code  = wbyte;

  // Reads take one wait state so FIFO data is in a register first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      addr_reg    <= '0;
    end else begin
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        rd_wait_reg <= 1'b0;
      end
      wr_pend_reg <= 1'b0;
      if (accept) begin
        addr_reg    <= haddr;
        wr_pend_reg <= hwrite;
        rd_pend_reg <= !hwrite;
        rd_wait_reg <= !hwrite;
      end
    end
  end

  // FIFO instances
  logic          txf_push;
  logic          txf_pop;
  logic [7:0]    txf_data;
  logic [CW-1:0] txf_count;
  logic          txf_empty;
  logic          txf_ovf;
  logic          rxf_push;
  logic          rxf_pop;
  logic [7:0]    rxf_wdata;
  logic [7:0]    rxf_data;
  logic [CW-1:0] rxf_count;
  logic          rxf_ovf;

  assign txf_push = wr_now && is_idx(addr_reg, rfl_pkg::IDX_FIFO_PORT);
  assign rxf_pop  = accept && !hwrite &&
                    is_idx(haddr, rfl_pkg::IDX_FIFO_PORT);

  rfl_fifo #(.WIDTH(rfl_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .push     (txf_push),
    .wr_data  (wbyte),
    .pop      (txf_pop),
    .rd_data  (txf_data),
    .count    (txf_count),
    .empty    (txf_empty),
    .full     (),
    .overflow (txf_ovf)
  );

  rfl_fifo #(.WIDTH(rfl_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .push     (rxf_push),
    .wr_data  (rxf_wdata),
    .pop      (rxf_pop),
    .rd_data  (rxf_data),
    .count    (rxf_count),
    .empty    (),
    .full     (),
    .overflow (rxf_ovf)
  );

  // Receive state
  logic        rx_active_reg;
  logic [12:0] rx_bits_reg;
  logic [7:0]  rx_shift_reg;
  logic [2:0]  rx_nbit_reg;
  logic [2:0]  rx_bytes_reg;
  logic [7:0]  rx_byte_full;
  logic [12:0] rx_bits_after;
  logic [12:0] rx_expected;
  logic [2:0]  rx_bytes_after;
  logic        rx_take;
  logic        rx_header_hit;
  logic        raw_mode;
  logic        skip_crc;

  assign skip_crc       = rx_len_high_reg[rfl_pkg::BIT_RX_SKIP_CRC];
  assign raw_mode       = rx_len_high_reg[rfl_pkg::BIT_RAW_FIFO];
  assign rx_take        = rx_active_reg && rx_bit_valid;
  assign rx_byte_full   = {rx_shift_reg[6:0], rx_bit};
  assign rx_bits_after  = rx_bits_reg + 13'h0001;
  assign rx_bytes_after = rx_bytes_reg + 3'h1;
  assign rx_header_hit  = rx_take && (rx_bits_reg == '0) && rx_bit;
  assign rxf_wdata      = rx_byte_full;
  assign rx_crc_check_en = !skip_crc;
  assign rx_expected = {1'b0, rx_len_high_reg[3:0], rx_len_low_reg} +
                       (skip_crc ? 13'h0000 : rfl_pkg::RX_CRC_BITS);

  // raw mode stores CRC bytes too
  assign rxf_push = rx_take && (rx_nbit_reg == 3'h7) &&
                    (raw_mode || skip_crc ||
                     rx_bits_after <= {1'b0, rx_len_high_reg[3:0],
                                       rx_len_low_reg});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_active_reg <= 1'b0;
      rx_bits_reg   <= '0;
      rx_shift_reg  <= '0;
      rx_nbit_reg   <= '0;
      rx_bytes_reg  <= '0;
    end else if (rx_start) begin
      rx_active_reg <= 1'b1;
      rx_bits_reg   <= '0;
      rx_nbit_reg   <= '0;
      rx_bytes_reg  <= '0;
    end else if (rx_end) begin
      rx_active_reg <= 1'b0;
    end else if (rx_take) begin
      rx_shift_reg <= rx_byte_full;
      rx_nbit_reg  <= rx_nbit_reg + 3'h1;
      if (rx_bits_reg != 13'h1FFF) begin
        rx_bits_reg <= rx_bits_after;
      end
      if (rx_nbit_reg == 3'h7 && rx_bytes_reg != 3'h7) begin
        rx_bytes_reg <= rx_bytes_after;
      end
    end
  end

  // Transmit engine
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_LOAD, TX_SHIFT} rfl_tx_st_t;
  rfl_tx_st_t  tx_state_reg;
  logic [11:0] tx_bytes_left_reg;
  logic [2:0]  tx_part_left_reg;
  logic [7:0]  tx_shift_reg;
  logic [3:0]  tx_nbits_reg;
  logic        tx_start_cmd;
  logic        tx_is_query;
  logic        tx_done;

  assign tx_is_query  = cmd_write && (cmd_code == rfl_pkg::CMD_QUERY);
  assign tx_start_cmd = cmd_write && (tx_is_query ||
                        cmd_code == rfl_pkg::CMD_TX_WITH_CRC ||
                        cmd_code == rfl_pkg::CMD_TX_ALT) &&
                        (tx_state_reg == TX_IDLE);
  assign tx_busy      = (tx_state_reg != TX_IDLE);
  assign tx_bit_valid = (tx_state_reg == TX_SHIFT);
  assign tx_bit       = tx_shift_reg[7];
  assign txf_pop = (tx_state_reg == TX_FETCH) && !txf_empty &&
                   (tx_bytes_left_reg != '0 || tx_part_left_reg != '0);
  assign tx_done = (tx_state_reg == TX_FETCH) &&
                   tx_bytes_left_reg == '0 && tx_part_left_reg == '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg      <= TX_IDLE;
      tx_bytes_left_reg <= '0;
      tx_part_left_reg  <= '0;
      tx_shift_reg      <= '0;
      tx_nbits_reg      <= '0;
      tx_frame_start    <= 1'b0;
      tx_hdr            <= '0;
    end else begin
      tx_frame_start <= 1'b0;
      unique case (tx_state_reg)
        TX_IDLE: begin
          if (tx_start_cmd) begin
            tx_bytes_left_reg <= {tx_len_high_reg, tx_len_low_reg[7:4]};
            tx_part_left_reg  <= tx_len_low_reg[3:1];
            tx_frame_start    <= 1'b1;
            tx_hdr.query      <= tx_is_query;
            tx_hdr.calibration <= tx_is_query ||
                                  tx_settings_reg[rfl_pkg::BIT_FORCE_CAL];
            tx_hdr.short_crc  <= tx_settings_reg[rfl_pkg::BIT_TX_SHORT_CRC];
            tx_hdr.session    <= tx_settings_reg[1:0];
            tx_state_reg      <= TX_FETCH;
          end
        end
        TX_FETCH: begin
          if (tx_done) begin
            tx_state_reg <= TX_IDLE;
          end else if (txf_pop) begin
            tx_state_reg <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          tx_shift_reg <= txf_data;
          if (tx_bytes_left_reg != '0) begin
            tx_nbits_reg      <= 4'h8;
            tx_bytes_left_reg <= tx_bytes_left_reg - 12'h001;
          end else begin
            tx_nbits_reg     <= {1'b0, tx_part_left_reg};
            tx_part_left_reg <= '0;
          end
          tx_state_reg <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tx_bit_ready) begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            tx_nbits_reg <= tx_nbits_reg - 4'h1;
            if (tx_nbits_reg == 4'h1) begin
              tx_state_reg <= TX_FETCH;
            end
          end
        end
      endcase
    end
  end

  // Register writes; hardware presets win over a host write
  logic       hw_len_load;
  logic [11:0] hw_len;

  always_comb begin
    hw_len_load = 1'b0;
    hw_len      = '0;
    if (rx_header_hit && rx_len_high_reg[rfl_pkg::BIT_AUTO_ERRCODE]) begin
      hw_len_load = 1'b1;
      hw_len      = rfl_pkg::LEN_ERROR_CODE;
    end else if (cmd_write && cmd_code >= rfl_pkg::CMD_QUERY &&
                 cmd_code <= rfl_pkg::CMD_SHORT_LAST) begin
      hw_len_load = 1'b1;
      hw_len      = rfl_pkg::LEN_SHORT_REPLY;
    end else if (cmd_write && cmd_code == rfl_pkg::CMD_SHORT_LONG) begin
      hw_len_load = 1'b1;
      hw_len      = rfl_pkg::LEN_LONG_REPLY;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_len_high_reg <= rfl_pkg::RST_BYTE;
      rx_len_low_reg  <= rfl_pkg::RST_BYTE;
    end else begin
      if (wr_now && is_idx(addr_reg, rfl_pkg::IDX_RX_LEN_HIGH)) begin
        rx_len_high_reg <= wbyte;
      end
      if (wr_now && is_idx(addr_reg, rfl_pkg::IDX_RX_LEN_LOW)) begin
        rx_len_low_reg <= wbyte;
      end
      if (hw_len_load) begin
        rx_len_high_reg[3:0] <= hw_len[11:8];
        rx_len_low_reg       <= hw_len[7:0];
      end
    end
  end

  // Reserved bits are kept at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_settings_reg <= rfl_pkg::RST_BYTE;
      tx_len_high_reg <= rfl_pkg::RST_BYTE;
      tx_len_low_reg  <= rfl_pkg::RST_BYTE;
      irq_mask_reg    <= rfl_pkg::RST_IRQ;
    end else if (wr_now) begin
      if (is_idx(addr_reg, rfl_pkg::IDX_TX_SETTINGS)) begin
        tx_settings_reg <= {4'h0, wbyte[3:0]};
      end
      if (is_idx(addr_reg, rfl_pkg::IDX_TX_LEN_HIGH_MID)) begin
        tx_len_high_reg <= wbyte;
      end
      if (is_idx(addr_reg, rfl_pkg::IDX_TX_LEN_LOW_PART)) begin
        tx_len_low_reg <= {wbyte[7:1], 1'b0};
      end
      if (is_own(addr_reg, rfl_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_reg <= wbyte[rfl_pkg::IRQ_BITS-1:0];
      end
    end
  end

  // Interrupt events
  always_comb begin
    irq_set = '0;
    irq_set[rfl_pkg::IRQ_TX_DONE] = tx_done;
    irq_set[rfl_pkg::IRQ_RX_DONE] = rx_active_reg && rx_end && !rx_start;
    // header irq only outside raw mode
    irq_set[rfl_pkg::IRQ_HEADER]  = rx_header_hit && !raw_mode;
    irq_set[rfl_pkg::IRQ_SECOND_BYTE] = rx_take && raw_mode &&
      rx_nbit_reg == 3'h7 && (rx_bytes_after == 3'h2 ||
      (rx_len_high_reg[rfl_pkg::BIT_REPEAT_IRQ] &&
       (rx_bytes_after == 3'h4 || rx_bytes_after == 3'h6)));
    irq_set[rfl_pkg::IRQ_LENGTH_ERROR] = irq_set[rfl_pkg::IRQ_RX_DONE] &&
      (rx_bits_reg < rx_expected);
    irq_set[rfl_pkg::IRQ_FIFO_OVERFLOW] = txf_ovf || rxf_ovf;
  end

  // A set in the same cycle as a clear survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= rfl_pkg::RST_IRQ;
    end else if (wr_now && is_own(addr_reg, rfl_pkg::ADDR_IRQ_STATUS)) begin
      irq_status_reg <= (irq_status_reg & ~wbyte[rfl_pkg::IRQ_BITS-1:0]) |
                        irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Read data is captured in the wait cycle
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (is_idx(addr_reg, rfl_pkg::IDX_RX_LEN_HIGH)) begin
      rd_byte = rx_len_high_reg;
    end else if (is_idx(addr_reg, rfl_pkg::IDX_RX_LEN_LOW)) begin
      rd_byte = rx_len_low_reg;
    end else if (is_idx(addr_reg, rfl_pkg::IDX_TX_SETTINGS)) begin
      rd_byte = tx_settings_reg;
    end else if (is_idx(addr_reg, rfl_pkg::IDX_TX_LEN_HIGH_MID)) begin
      rd_byte = tx_len_high_reg;
    end else if (is_idx(addr_reg, rfl_pkg::IDX_TX_LEN_LOW_PART)) begin
      rd_byte = tx_len_low_reg;
    end else if (is_idx(addr_reg, rfl_pkg::IDX_FIFO_PORT)) begin
      rd_byte = rxf_data;
    end else if (is_own(addr_reg, rfl_pkg::ADDR_IRQ_STATUS)) begin
      rd_byte = {2'b00, irq_status_reg};
    end else if (is_own(addr_reg, rfl_pkg::ADDR_IRQ_MASK)) begin
      rd_byte = {2'b00, irq_mask_reg};
    end else if (is_own(addr_reg, rfl_pkg::ADDR_FIFO_STATUS)) begin
      rd_byte = {tx_busy, rx_active_reg, 1'b0, 5'(rxf_count)};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_wait_reg) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  logic unused_ok;
  assign unused_ok = ^{hsize, hwdata[31:8], txf_count};
endmodule : rfl_frame_ctrl

// ===== bench/rfl_frame_ctrl_assertions.sv
// Port-level assertions for the frame control block
`timescale 1ns/1ns
module rfl_ctrl_chk (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [1:0]           htrans,
  input wire logic                 hready,
  input wire logic                 hwrite,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic                 tx_frame_start,
  input wire rfl_pkg::rfl_tx_hdr_t tx_hdr,
  input wire logic                 tx_bit,
  input wire logic                 tx_bit_valid,
  input wire logic                 tx_bit_ready,
  input wire logic                 tx_busy
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_fast_a: assert property (
    hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  start_busy_a: assert property (
    tx_frame_start |-> tx_busy ##1 !tx_frame_start)
    else $error("start pulse wrong");
  bit_hold_a: assert property (
    tx_bit_valid && !tx_bit_ready |=> tx_bit_valid && $stable(tx_bit))
    else $error("bit dropped while stalled");
  valid_busy_a: assert property (tx_bit_valid |-> tx_busy)
    else $error("bit outside frame");
  hdr_hold_a: assert property (
    tx_busy && !tx_frame_start |-> $stable(tx_hdr))
    else $error("header moved in frame");
  query_cal_a: assert property (
    tx_busy && tx_hdr.query |-> tx_hdr.calibration)
    else $error("query without calibration");
endmodule : rfl_ctrl_chk
bind rfl_frame_ctrl rfl_ctrl_chk i_chk (.hclk, .hresetn, .hsel, .htrans,
  .hready, .hwrite, .hreadyout, .hresp, .tx_frame_start, .tx_hdr, .tx_bit,
  .tx_bit_valid, .tx_bit_ready, .tx_busy);

// ===== bench/rfl_mod_model.sv
// Modulator stand-in that takes transmit bits
`timescale 1ns/1ns
module rfl_mod_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic slow,
  input  wire logic tx_bit,
  input  wire logic tx_bit_valid,
  output logic      tx_bit_ready
);
  logic [31:0] bits_reg;
  int          n_bits;
  // Slow mode stalls every other cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tx_bit_ready <= 1'b0;
    else
      tx_bit_ready <= slow ? !tx_bit_ready : 1'b1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bits_reg <= '0;
      n_bits <= 0;
    end else if (tx_bit_valid && tx_bit_ready) begin
      bits_reg <= {bits_reg[30:0], tx_bit};
      n_bits <= n_bits + 1;
    end
  end
endmodule : rfl_mod_model

// ===== bench/tb_top.sv
// Register-level test of the frame control block
`timescale 1ns/1ns
module tb_top;
  logic                 hclk, hresetn, hsel, hwrite, irq, slow;
  logic [31:0]          haddr, hwdata, hrdata;
  logic [1:0]           htrans;
  wire logic            hready;
  logic                 hreadyout, tx_frame_start, tx_bit, tx_bit_valid;
  logic                 tx_bit_ready, tx_busy, rx_crc_check_en;
  logic                 rx_start, rx_bit_valid, rx_bit, rx_end;
  rfl_pkg::rfl_tx_hdr_t tx_hdr;
  logic [7:0]           q;
  int                   n_fail, num_checks;
  logic [7:0] pc [3] = '{8'h99, 8'h9C, 8'h9F};
  logic [7:0] pe [3] = '{8'h10, 8'h10, 8'h20};
  logic [7:0] tc [2] = '{8'h91, 8'h98};
  logic [4:0] th [2] = '{5'b01010, 5'b11010};
  assign hready = hreadyout;
  rfl_frame_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp(), .irq,
    .tx_frame_start, .tx_hdr, .tx_bit, .tx_bit_valid, .tx_bit_ready,
    .tx_busy, .rx_crc_check_en, .rx_start, .rx_bit_valid, .rx_bit, .rx_end);
  rfl_mod_model i_mod (.hclk, .hresetn, .slow, .tx_bit, .tx_bit_valid,
    .tx_bit_ready);
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Register index times four is the byte address
  task automatic bus(input logic [7:0] idx, input logic w,
                     input logic [7:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 99);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 99);
    q = hrdata[7:0];
    if (k >= 99) begin
      n_fail++;
      finish_test();
    end
  endtask : bus
  task automatic rd(input logic [7:0] idx, e);
    bus(idx, 1'b0, 8'h00);
    chk($sformatf("reg %h", idx), q, e);
  endtask : rd
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (2) @(posedge hclk);
    while (tx_busy !== 1'b0 && ++k < 2000) @(posedge hclk);
    if (k >= 2000) begin
      n_fail++;
      finish_test();
    end
  endtask : wait_idle
  // Bits go out most significant first
  task automatic rx(input logic [15:0] v, input int n);
    rx_start <= 1'b1;
    @(posedge hclk);
    rx_start <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      rx_bit_valid <= 1'b1;
      rx_bit <= v[i];
      @(posedge hclk);
    end
    rx_bit_valid <= 1'b0;
    rx_end <= 1'b1;
    @(posedge hclk);
    rx_end <= 1'b0;
  endtask : rx
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, rx_start, rx_bit_valid, rx_bit, rx_end} = '0;
    {haddr, hwdata, htrans, n_fail, num_checks} = '0;
    slow = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 8'h3A; i <= 8'h40; i++) rd(8'(i), 8'h00);
    bus(8'h3C, 1'b1, 8'hFF);
    rd(8'h3C, 8'h0F);
    bus(8'h3A, 1'b1, 8'h80);
    // Write lands on the edge the task returns at
    @(posedge hclk);
    chk("crc_en", rx_crc_check_en, 0);
    foreach (pc[i]) begin
      bus(8'h00, 1'b1, pc[i]);
      rd(8'h3B, pe[i]);
    end
    bus(8'h3C, 1'b1, 8'h0A);
    bus(8'h3E, 1'b1, 8'h26);
    bus(8'h3F, 1'b1, 8'hA5);
    bus(8'h3F, 1'b1, 8'h3C);
    bus(8'h3F, 1'b1, 8'hE0);
    bus(8'h02, 1'b1, 8'h01);
    bus(8'h00, 1'b1, 8'h90);
    wait_idle();
    rd(8'h3E, 8'h26);
    chk("bits", i_mod.bits_reg, {8'hA5, 8'h3C, 3'b111});
    chk("count", i_mod.n_bits, 19);
    chk("hdr", tx_hdr, 5'b00110);
    chk("irq", irq, 1);
    bus(8'h01, 1'b1, 8'hFF);
    bus(8'h02, 1'b1, 8'h00);
    bus(8'h3E, 1'b1, 8'h00);
    bus(8'h3C, 1'b1, 8'h06);
    foreach (tc[i]) begin
      bus(8'h00, 1'b1, tc[i]);
      wait_idle();
      chk("hdr", tx_hdr, th[i]);
    end
    rd(8'h01, 8'h01);
    chk("irq masked", irq, 0);
    bus(8'h01, 1'b1, 8'hFF);
    bus(8'h3B, 1'b1, 8'h08);
    rx(16'h0043, 8);
    rd(8'h01, 8'h02);
    rd(8'h3F, 8'h43);
    bus(8'h01, 1'b1, 8'hFF);
    rx(16'h0004, 4);
    rd(8'h01, 8'h12);
    rd(8'h3F, 8'h00);
    bus(8'h01, 1'b1, 8'hFF);
    bus(8'h3A, 1'b1, 8'h40);
    bus(8'h3B, 1'b1, 8'h00);
    rx(16'hC3C3, 16);
    rd(8'h01, 8'h0A);
    rd(8'h3F, 8'hC3);
    rd(8'h03, 8'h01);
    bus(8'h3A, 1'b1, 8'h10);
    rx(16'h0001, 1);
    rd(8'h3B, 8'h29);
    rd(8'h01, 8'h1E);
    finish_test();
  end
endmodule : tb_top
